// [sdma_cfg.svh]
`ifndef SDMA_CFG_SVH
`define SDMA_CFG_SVH

// processor byte address of the display window: A23..A14 match, word index below size
`define SDMA_REGION_BASE     10'h3F0
`define SDMA_MEM_WORDS       13'h1800
`define SDMA_ADDR_W          13
`define SDMA_WORD_W          12
`define SDMA_MODE_W          4
`define SDMA_MODE_LSB        12
`define SDMA_MODE_RESET      4'h0
// memory access time and the longest access time each tap covers, in ns
`define SDMA_MEM_ACCESS_NS   300
`define SDMA_TAP0_ACCESS_NS  250
`define SDMA_TAP1_ACCESS_NS  375
`define SDMA_TAP2_ACCESS_NS  500
`define SDMA_TAP3_ACCESS_NS  625
`define SDMA_WAITS_PER_TAP   2
`define SDMA_CHAIN_LEN       7

`endif

// [sdma_pkg.sv]
`include "sdma_cfg.svh"

package sdma_pkg;

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h1,
		ST_ISOLATE = 4'h2,
		ST_CONNECT = 4'h4,
		ST_ACK     = 4'h8
	} sdma_state_t;

	typedef enum logic [1:0] {
		TAP_ZERO_WAIT = 2'h0,
		TAP_TWO_WAIT  = 2'h1,
		TAP_FOUR_WAIT = 2'h2,
		TAP_SIX_WAIT  = 2'h3
	} sdma_tap_t;

	// shortest tap whose access-time limit covers the memory
	function automatic sdma_tap_t sdma_pick_tap(input int access_ns);
		if (access_ns <= `SDMA_TAP0_ACCESS_NS) return TAP_ZERO_WAIT;
		else if (access_ns <= `SDMA_TAP1_ACCESS_NS) return TAP_TWO_WAIT;
		else if (access_ns <= `SDMA_TAP2_ACCESS_NS) return TAP_FOUR_WAIT;
		else return TAP_SIX_WAIT;
	endfunction : sdma_pick_tap

	// connected cycles counted before the last one, whose end loads the acknowledge register
	function automatic int sdma_connect_cycles(input sdma_tap_t tap);
		return 1 + `SDMA_WAITS_PER_TAP * int'(tap);
	endfunction : sdma_connect_cycles

endpackage : sdma_pkg

// [sdma_ack_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface sdma_ack_if;
	logic                 start;
	sdma_pkg::sdma_tap_t  tap;
	logic                 done;

	modport ctl   (output start, output tap, input done);
	modport chain (input start, input tap, output done);
endinterface : sdma_ack_if

`default_nettype wire

// [sdma_ack_chain.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sdma_cfg.svh"

module sdma_ack_chain (
	// clock and reset
	input  wire logic  core_clk_i,
	input  wire logic  nrst_i,
	// control
	sdma_ack_if.chain  ack
);

	logic [`SDMA_CHAIN_LEN-1:0] chain_ff;
	logic                       tap_zero_wait;
	logic                       tap_two_wait;
	logic                       tap_four_wait;
	logic                       tap_six_wait;

	// ones shift in while the access runs; dropping start empties it at once
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			chain_ff <= '0;
		end else if (!ack.start) begin
			chain_ff <= '0;
		end else begin
			chain_ff <= {chain_ff[`SDMA_CHAIN_LEN-2:0], 1'b1};
		end
	end

	assign tap_zero_wait = chain_ff[0];
	assign tap_two_wait  = chain_ff[2];
	assign tap_four_wait = chain_ff[4];
	assign tap_six_wait  = chain_ff[6];

	always_comb begin
		unique case (ack.tap)
			sdma_pkg::TAP_ZERO_WAIT: ack.done = tap_zero_wait;
			sdma_pkg::TAP_TWO_WAIT:  ack.done = tap_two_wait;
			sdma_pkg::TAP_FOUR_WAIT: ack.done = tap_four_wait;
			sdma_pkg::TAP_SIX_WAIT:  ack.done = tap_six_wait;
		endcase
	end

endmodule : sdma_ack_chain

`default_nettype wire

// [sdma_arbiter.sv]
// Operation
// - The display memory is owned by the processor or the video generator, never both.
// - A processor address inside the 6K display region moves ownership to the processor.
// - The generator address bus is released first, then processor address and data connect.
// - Processor buffers are enabled only during a processor display access.
// - With no processor access the generator's address path drives memory for scanning.
// - Memory words are 12 bits; a separate 4-bit latch holds generator mode data.
// - The mode latch loads only on processor writes to even addresses and holds otherwise.
// - A processor display access that holds its strobe until the delay chain's tap fires ends with a transfer acknowledge; dropping it earlier gives none.
// - Delay chain taps give zero, two, four or six wait states.
// - The tap follows memory access time; 300 ns parts use the two-wait tap.
`timescale 1ns/1ps
`default_nettype none
`include "sdma_cfg.svh"

module sdma_arbiter (
	// clock and reset
	input  wire logic                          core_clk_i,
	input  wire logic                          nrst_i,
	// processor bus
	input  wire logic                          cpu_as_n_i,
	input  wire logic                          cpu_rw_i,
	input  wire logic [23:1]                   cpu_addr_i,
	input  wire logic [15:0]                   cpu_wdata_i,
	output var  logic [15:0]                   cpu_rdata_o,
	output var  logic                          cpu_rdata_oe_o,
	output var  logic                          cpu_buf_en_o,
	output var  logic                          transfer_acknowledge_n_o,
	// video generator
	input  wire logic [`SDMA_ADDR_W-1:0]       video_generator_addr_i,
	output var  logic                          video_generator_addr_en_o,
	output var  logic [`SDMA_MODE_W-1:0]       video_generator_mode_o,
	// display memory
	output var  logic [`SDMA_ADDR_W-1:0]       mem_addr_o,
	output var  logic [`SDMA_WORD_W-1:0]       mem_wdata_o,
	output var  logic                          mem_we_o,
	input  wire logic [`SDMA_WORD_W-1:0]       mem_rdata_i
);

	localparam sdma_pkg::sdma_tap_t ACK_TAP = sdma_pkg::sdma_pick_tap(`SDMA_MEM_ACCESS_NS);
	localparam int CONNECT_CYCLES = sdma_pkg::sdma_connect_cycles(ACK_TAP);

	sdma_pkg::sdma_state_t state_ff;
	sdma_pkg::sdma_state_t nxt_state;
	logic                  region_hit;
	logic                  cpu_write;

	sdma_ack_if ack ();

	sdma_ack_chain u_chain (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.ack        (ack.chain)
	);

	assign ack.start = (state_ff == sdma_pkg::ST_CONNECT);
	assign ack.tap   = ACK_TAP;

	// window decode: upper address matches and word index below 6K
	assign region_hit = !cpu_as_n_i && (cpu_addr_i[23:14] == `SDMA_REGION_BASE)
		&& (cpu_addr_i[13:1] < `SDMA_MEM_WORDS);
	assign cpu_write  = !cpu_rw_i;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			sdma_pkg::ST_IDLE: begin
				if (region_hit) begin
					nxt_state = sdma_pkg::ST_ISOLATE;
				end
			end
			sdma_pkg::ST_ISOLATE: begin
				nxt_state = cpu_as_n_i ? sdma_pkg::ST_IDLE : sdma_pkg::ST_CONNECT;
			end
			sdma_pkg::ST_CONNECT: begin
				if (cpu_as_n_i) begin
					nxt_state = sdma_pkg::ST_IDLE;
				end else if (ack.done) begin
					nxt_state = sdma_pkg::ST_ACK;
				end
			end
			sdma_pkg::ST_ACK: begin
				if (cpu_as_n_i) begin
					nxt_state = sdma_pkg::ST_IDLE;
				end
			end
			default: nxt_state = sdma_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_ff <= sdma_pkg::ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ownership: generator bus drops one cycle before processor buffers open
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			video_generator_addr_en_o <= 1'b1;
			cpu_buf_en_o              <= 1'b0;
		end else begin
			video_generator_addr_en_o <= (nxt_state == sdma_pkg::ST_IDLE);
			cpu_buf_en_o              <= (nxt_state == sdma_pkg::ST_CONNECT)
				|| (nxt_state == sdma_pkg::ST_ACK);
		end
	end

	// memory address mux and write path
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mem_addr_o  <= '0;
			mem_wdata_o <= '0;
			mem_we_o    <= 1'b0;
		end else begin
			if (nxt_state == sdma_pkg::ST_IDLE || nxt_state == sdma_pkg::ST_ISOLATE) begin
				mem_addr_o <= video_generator_addr_i;
			end else begin
				mem_addr_o <= cpu_addr_i[13:1];
			end
			mem_wdata_o <= cpu_wdata_i[`SDMA_WORD_W-1:0];
			mem_we_o    <= (nxt_state == sdma_pkg::ST_CONNECT) && cpu_write;
		end
	end

	// read data is sampled every connected cycle so the last one before the ack wins
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cpu_rdata_o    <= '0;
			cpu_rdata_oe_o <= 1'b0;
		end else begin
			if (state_ff == sdma_pkg::ST_CONNECT) begin
				cpu_rdata_o <= {{(16-`SDMA_WORD_W){1'b0}}, mem_rdata_i};
			end
			cpu_rdata_oe_o <= (nxt_state == sdma_pkg::ST_CONNECT || nxt_state == sdma_pkg::ST_ACK)
				&& !cpu_write;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			transfer_acknowledge_n_o <= 1'b1;
		end else begin
			transfer_acknowledge_n_o <= (nxt_state != sdma_pkg::ST_ACK);
		end
	end

	// mode bits only change at the end of an even-word write, at any point in the generator's frame
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			video_generator_mode_o <= `SDMA_MODE_RESET;
		end else if (state_ff == sdma_pkg::ST_CONNECT && nxt_state == sdma_pkg::ST_ACK
				&& cpu_write && !cpu_addr_i[1]) begin
			video_generator_mode_o <= cpu_wdata_i[`SDMA_MODE_LSB +: `SDMA_MODE_W];
		end
	end

	// helper: connected cycles counted for the wait-state check
	logic [3:0] conn_cnt_ff;

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			conn_cnt_ff <= '0;
		end else if (state_ff == sdma_pkg::ST_CONNECT) begin
			conn_cnt_ff <= conn_cnt_ff + 4'h1;
		end else if (state_ff == sdma_pkg::ST_IDLE) begin
			conn_cnt_ff <= '0;
		end
	end

	sequence s_request;
		state_ff == sdma_pkg::ST_IDLE && region_hit;
	endsequence

	sequence s_handover;
		!video_generator_addr_en_o && !cpu_buf_en_o ##1 !video_generator_addr_en_o && cpu_buf_en_o;
	endsequence

	a_single_owner: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		!(video_generator_addr_en_o && cpu_buf_en_o))
		else $error("memory owned by both parties");

	a_grant_order: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		s_request ##1 !cpu_as_n_i |-> s_handover)
		else $error("processor grant out of order");

	a_buf_in_access: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		cpu_buf_en_o |-> state_ff == sdma_pkg::ST_CONNECT || state_ff == sdma_pkg::ST_ACK)
		else $error("processor buffers open outside access");

	a_video_scan: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		state_ff == sdma_pkg::ST_IDLE && $past(state_ff) == sdma_pkg::ST_IDLE && $past(nrst_i)
		|-> video_generator_addr_en_o && mem_addr_o == $past(video_generator_addr_i))
		else $error("generator path not selected while idle");

	a_word_width: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		mem_we_o |-> mem_wdata_o == $past(cpu_wdata_i[11:0]) && cpu_buf_en_o)
		else $error("write data not the low twelve bits");

	a_mode_source: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		$changed(video_generator_mode_o)
		|-> $past(!cpu_rw_i && !cpu_addr_i[1] && state_ff == sdma_pkg::ST_CONNECT))
		else $error("mode latch changed without even write");

	a_ack_bounded: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		$rose(cpu_buf_en_o) ##1 !cpu_as_n_i [*3] |-> ##[1:8] !transfer_acknowledge_n_o)
		else $error("no transfer acknowledge");

	a_wait_states: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		$fell(transfer_acknowledge_n_o) |-> $past(conn_cnt_ff) == 4'(CONNECT_CYCLES))
		else $error("acknowledge wait count wrong");

	a_idle_quiet: assert property (
		@(posedge core_clk_i) disable iff (!nrst_i)
		state_ff == sdma_pkg::ST_IDLE |=> transfer_acknowledge_n_o && !ack.done)
		else $error("acknowledge or chain active while idle");

endmodule : sdma_arbiter

`default_nettype wire

// [sdma_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sdma_cfg.svh"

module sdma_far_model (
	// clock
	input  wire logic                    core_clk_i,
	// display memory
	input  wire logic [`SDMA_ADDR_W-1:0] mem_addr_i,
	input  wire logic [`SDMA_WORD_W-1:0] mem_wdata_i,
	input  wire logic                    mem_we_i,
	output var  logic [`SDMA_WORD_W-1:0] mem_rdata_o,
	// generator scan address
	output var  logic [`SDMA_ADDR_W-1:0] scan_addr_o
);
	logic [`SDMA_WORD_W-1:0] ram_ff [0:`SDMA_MEM_WORDS-1];
	logic [`SDMA_ADDR_W-1:0] scan_ff = '0;

	// scan wraps at the window size, never fetching past the last word
	always_ff @(posedge core_clk_i) begin
		scan_ff <= (scan_ff == `SDMA_MEM_WORDS - 1) ? '0 : scan_ff + 1'b1;
	end

	always_ff @(posedge core_clk_i) begin
		if (mem_we_i) begin
			ram_ff[mem_addr_i] <= mem_wdata_i;
		end
	end

	assign scan_addr_o = scan_ff;
	assign mem_rdata_o = ram_ff[mem_addr_i];
endmodule : sdma_far_model

`default_nettype wire

// [shared_display_memory_arbiter_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sdma_cfg.svh"

module shared_display_memory_arbiter_bench;
	logic        clk = 1'b0;
	logic        nrst_i;
	logic        as_n;
	logic        rw;
	logic [23:1] addr;
	logic [15:0] wd;
	logic [15:0] rd;
	logic        rd_oe;
	logic        buf_en;
	logic        ack_n;
	logic [12:0] gen_a;
	logic        a_en;
	logic [3:0]  mode;
	logic [12:0] m_a;
	logic [11:0] m_wd;
	logic        m_we;
	logic [11:0] m_rd;
	int          num_errors = 0;
	int          check_count = 0;
	logic [11:0] shadow [int];
	logic [3:0]  exp_mode;
	logic [15:0] v;
	int          w;
	int          q [$];

	initial begin
		forever #4 clk = ~clk;
	end

	sdma_arbiter dut (.core_clk_i(clk), .nrst_i(nrst_i), .cpu_as_n_i(as_n), .cpu_rw_i(rw),
		.cpu_addr_i(addr), .cpu_wdata_i(wd), .cpu_rdata_o(rd), .cpu_rdata_oe_o(rd_oe),
		.cpu_buf_en_o(buf_en), .transfer_acknowledge_n_o(ack_n),
		.video_generator_addr_i(gen_a), .video_generator_addr_en_o(a_en),
		.video_generator_mode_o(mode), .mem_addr_o(m_a), .mem_wdata_o(m_wd),
		.mem_we_o(m_we), .mem_rdata_i(m_rd));

	sdma_far_model far (.core_clk_i(clk), .mem_addr_i(m_a), .mem_wdata_i(m_wd),
		.mem_we_i(m_we), .mem_rdata_o(m_rd), .scan_addr_o(gen_a));

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up

	// negedges from strobe to seen acknowledge: taken, isolate, connect, load, plus waits
	function automatic int exp_ack_edges(input int access_ns);
		int waits;
		if (access_ns <= `SDMA_TAP0_ACCESS_NS) waits = 0;
		else if (access_ns <= `SDMA_TAP1_ACCESS_NS) waits = `SDMA_WAITS_PER_TAP;
		else if (access_ns <= `SDMA_TAP2_ACCESS_NS) waits = 2 * `SDMA_WAITS_PER_TAP;
		else waits = 3 * `SDMA_WAITS_PER_TAP;
		return 4 + waits;
	endfunction : exp_ack_edges

	// generator owns memory, address follows scan one cycle late
	task automatic idle_check();
		check("idle", {ack_n, buf_en, a_en, rd_oe}, 16'hA);
		check("scan addr", m_a, (gen_a == 13'h0) ? 13'h17FF : gen_a - 1'b1);
	endtask : idle_check

	// frame sync has no pin: bench writes stand for writes at any point in the frame
	task automatic access(input logic [12:0] wi, input logic r, input logic [15:0] d);
		int n;
		@(negedge clk);
		as_n = 1'b0;
		rw = r;
		addr = {10'h3F0, wi};
		wd = d;
		n = 0;
		while (ack_n !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
			check("exclusive", {15'h0, a_en & buf_en}, 16'h0);
			if (n == 1) check("isolate", {a_en, buf_en}, 16'h0);
			if (n == 2) check("connect", {a_en, buf_en, rd_oe}, {14'h1, r});
			if (n == 2) check("mem addr", m_a, wi);
		end
		check("ack delay", n, 16'(exp_ack_edges(`SDMA_MEM_ACCESS_NS)));
		if (n >= 20) wrap_up();
		v = rd;
		as_n = 1'b1;
		@(negedge clk);
		idle_check();
	endtask : access

	task automatic wr(input logic [12:0] wi, input logic [15:0] d);
		access(wi, 1'b0, d);
		shadow[wi] = d[11:0];
		if (!wi[0]) exp_mode = d[15:12];
		check("mode", mode, exp_mode);
	endtask : wr

	task automatic refused(input logic [23:1] a, input int held);
		@(negedge clk);
		as_n = 1'b0;
		rw = 1'b1;
		addr = a;
		repeat (held) @(negedge clk);
		as_n = 1'b1;
		repeat (8) begin
			@(negedge clk);
			check("no ack", {ack_n, buf_en}, 16'h2);
		end
		idle_check();
	endtask : refused

	initial begin
		void'($urandom(32'h877C));
		nrst_i = 1'b0;
		as_n = 1'b1;
		rw = 1'b1;
		addr = '0;
		wd = '0;
		exp_mode = 4'h0;
		repeat (16) @(negedge clk);
		nrst_i = 1'b1;
		@(negedge clk);
		check("reset mode", mode, 16'h0);
		idle_check();
		wr(13'h0000, 16'hA123);
		wr(13'h17FF, 16'h5FED);
		wr(13'h0001, 16'h3456);
		repeat (12) begin
			w = $urandom_range(0, 13'h17FF);
			wr(w[12:0], 16'($urandom));
			q.push_back(w);
		end
		q.push_back(0);
		q.push_back(13'h17FF);
		foreach (q[i]) begin
			access(q[i][12:0], 1'b1, 16'h0);
			check("read", v, {4'h0, shadow[q[i]]});
			check("mode hold", mode, exp_mode);
		end
		refused({10'h3F0, 13'h1800}, 8);
		refused({10'h3EF, 13'h0000}, 8);
		refused({10'h3F0, 13'h0004}, 2);
		access(13'h0000, 1'b1, 16'h0);
		check("after abort", v, {4'h0, shadow[0]});
		wrap_up();
	end
endmodule : shared_display_memory_arbiter_bench

`default_nettype wire
